// [src/play_if.sv]
/*
  Carrier between the sequencer core, its rate timer and its waveform RAM.
  Assumes one clock; ce freezes every party at once.
*/
`timescale 1ns/1ps
`default_nettype none

interface play_if;
    import seq_pkg::*;
    logic ce;
    logic tm_run;
    logic tm_load;
    logic [RATE_W-1:0] tm_period;
    logic tm_expire;
    logic wr_en;
    logic [ADDR_W-1:0] wr_addr;
    logic [31:0] wr_data;
    logic [ADDR_W-1:0] rd_addr;
    logic [31:0] rd_data;
    modport ctl (output ce, tm_run, tm_load, tm_period, wr_en, wr_addr, wr_data, rd_addr,
                 input tm_expire, rd_data);
    modport timer (input ce, tm_run, tm_load, tm_period, output tm_expire);
    modport mem (input ce, wr_en, wr_addr, wr_data, rd_addr, output rd_data);
endinterface // play_if

`default_nettype wire

// [src/ram_internal_profile_sequencer.sv]
/*
  Internal profile sequencer for RAM playback, with its APB register file,
  interrupt status and destination routing of the played words.
  Assumes one clock; all bus inputs are synchronous to REF_CLK.
*/
// Added by the designer: the APB slave port and the register addresses.
// Behaviour
// - Field 20:17 selects; 0000 off, 1111 invalid.
// - Codes 1-7 burst profile 0 to code.
// - Codes 8-14 loop profile 0 to code-7.
// - Per-profile mode bits ignored while sequencing.
// - No-dwell setting ignored while sequencing.
// - Profile select pins ignored while sequencing.
// - Sequence starts with profile 0 parameters.
// - Expiry after end loads next profile.
// - Burst halts on expiry after last end.
// - Continuous wraps to profile 0 until recommit.
// - Commit latches field, clears done, restarts.
// - Done output high two cycles per end.
// - Address steps upward at profile's own rate.
// - Profile regions may lie anywhere in RAM.
// - One address step per timer expiry.
// - RAM disabled forces done output low.
// - Field 30:29 routes words to destination.
`include "seq_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module ram_internal_profile_sequencer
    import seq_pkg::*;
(
    input wire logic REF_CLK,
    input wire logic RESETN,
    input wire logic CE,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic [2:0] PROFILE_SEL,
    output logic SWEEP_DONE_OUT,
    output logic [31:0] FREQ_WORD,
    output logic [15:0] PHASE_WORD,
    output logic [13:0] AMP_WORD,
    output logic IRQ
);

    ////////////////////////////////////////////////////////////////////////

    top_state_t s;
    top_state_t next_s;
    play_if pi ();

    logic setup;
    logic access;
    logic mapped;
    logic is_prof;
    logic [2:0] pidx;
    logic commit;
    logic hit;
    logic ev_end;
    logic ev_burst;
    logic [2:0] last;
    logic [2:0] tgt;

    rate_timer u_timer (
        .clk(REF_CLK),
        .rst_n(RESETN),
        .p(pi.timer)
    );

    wave_ram u_ram (
        .clk(REF_CLK),
        .rst_n(RESETN),
        .p(pi.mem)
    );

    assign pi.ce = CE;

    ////////////////////////////////////////////////////////////////////////

    assign setup = PSEL && !PENABLE;
    assign access = PSEL && PENABLE && s.pready;
    assign is_prof = (PADDR & `PROF_MASK) == `PROF_BASE;
    assign pidx = PADDR[5:3];

    always_comb
    begin
        unique case (PADDR)
            `CTRL_OFS, `COMMIT_OFS, `RAMPTR_OFS, `RAMDAT_OFS,
            `STATUS_OFS, `IRQST_OFS, `IRQMSK_OFS:
                mapped = PADDR[1:0] == 2'h0;
            default:
                mapped = is_prof && (PADDR[1:0] == 2'h0);
        endcase
    end

    // Burst and continuous codes share the last profile; continuous is offset.
    assign last = s.seq[3] ? 3'(s.seq - `SEQ_WRAP_OFS) : s.seq[2:0];

    ////////////////////////////////////////////////////////////////////////

    always_comb
    begin
        next_s = s;
        next_s.pready = 1'b0;
        next_s.pslverr = 1'b0;
        commit = 1'b0;
        hit = 1'b0;
        ev_end = 1'b0;
        ev_burst = 1'b0;
        tgt = '0;
        pi.tm_load = 1'b0;
        pi.tm_period = s.profs[0].rate;
        pi.wr_en = 1'b0;
        pi.wr_addr = s.ram_ptr;
        pi.wr_data = PWDATA;
        pi.tm_run = s.state == SEQ_RUN;

        // Read data is captured in the setup cycle; the access phase always
        // completes one cycle later, so the bus sees a fixed no-wait answer.
        if (setup)
        begin
            next_s.pready = 1'b1;
            next_s.pslverr = !mapped;
            next_s.prdata = '0;
            if (is_prof && !PADDR[2])
            begin
                next_s.prdata[ADDR_W-1:0] = s.profs[pidx].start_a;
                next_s.prdata[`PROF_END_MSB:`PROF_END_LSB] = s.profs[pidx].end_a;
            end
            else if (is_prof)
            begin
                // Mode and no-dwell bits are not held; they read as zero.
                next_s.prdata[RATE_W-1:0] = s.profs[pidx].rate;
            end
            else
            begin
                unique case (PADDR)
                    `CTRL_OFS:
                        next_s.prdata = s.ctrl;
                    `RAMPTR_OFS:
                        next_s.prdata[ADDR_W-1:0] = s.ram_ptr;
                    `STATUS_OFS:
                    begin
                        next_s.prdata[`STAT_RUN_BIT] = s.state == SEQ_RUN;
                        next_s.prdata[`STAT_DONE_BIT] = s.burst_done;
                        next_s.prdata[`STAT_CUR_LSB +: 3] = s.cur;
                        next_s.prdata[`STAT_ADDR_LSB +: ADDR_W] = s.addr;
                    end
                    `IRQST_OFS:
                        next_s.prdata[1:0] = s.irq_st;
                    `IRQMSK_OFS:
                        next_s.prdata[1:0] = s.irq_mask;
                    default:
                        next_s.prdata = '0;
                endcase
            end
            if (!mapped)
                next_s.prdata = '0;
        end

        if (access && PWRITE && !s.pslverr)
        begin
            if (is_prof && !PADDR[2])
            begin
                next_s.profs[pidx].start_a = PWDATA[ADDR_W-1:0];
                next_s.profs[pidx].end_a = PWDATA[`PROF_END_MSB:`PROF_END_LSB];
            end
            else if (is_prof)
            begin
                next_s.profs[pidx].rate = PWDATA[RATE_W-1:0];
            end
            else
            begin
                unique case (PADDR)
                    `CTRL_OFS:
                        next_s.ctrl = PWDATA;
                    `COMMIT_OFS:
                        commit = 1'b1;
                    `RAMPTR_OFS:
                        next_s.ram_ptr = PWDATA[ADDR_W-1:0];
                    `RAMDAT_OFS:
                    begin
                        pi.wr_en = 1'b1;
                        next_s.ram_ptr = s.ram_ptr + 1'b1;
                    end
                    `IRQMSK_OFS:
                        next_s.irq_mask = PWDATA[1:0];
                    default:
                        next_s.ram_ptr = s.ram_ptr;
                endcase
            end
        end

        ////////////////////////////////////////////////////////////////////
        // Sequencer.

        if (s.pulse_cnt != '0)
            next_s.pulse_cnt = s.pulse_cnt - 1'b1;

        if (commit)
        begin
            next_s.seq = s.ctrl[`CTRL_SEQ_MSB:`CTRL_SEQ_LSB];
            next_s.dest = s.ctrl[`CTRL_DEST_MSB:`CTRL_DEST_LSB];
            next_s.ram_en = s.ctrl[`CTRL_RAMEN_BIT];
            next_s.burst_done = 1'b0;
            next_s.pulse_cnt = '0;
            next_s.cur = '0;
            // The invalid code is treated as off rather than as a sequence.
            if (next_s.seq == `SEQ_OFF || next_s.seq == `SEQ_INVALID)
                next_s.state = SEQ_IDLE;
            else
                next_s.state = SEQ_RUN;
            next_s.addr = s.profs[0].start_a;
            pi.tm_load = 1'b1;
            pi.tm_period = s.profs[0].rate;
            hit = next_s.state == SEQ_RUN && s.profs[0].start_a == s.profs[0].end_a;
        end
        else if (s.state == SEQ_RUN && pi.tm_expire)
        begin
            if (!s.at_end)
            begin
                // Ten-bit wrap lets a region run across the top of RAM.
                next_s.addr = s.addr + 1'b1;
                hit = next_s.addr == s.profs[s.cur].end_a;
            end
            else if (s.cur == last && !s.seq[3])
            begin
                next_s.state = SEQ_HALT;
                next_s.burst_done = 1'b1;
                ev_burst = 1'b1;
            end
            else
            begin
                tgt = (s.cur == last) ? 3'h0 : s.cur + 1'b1;
                next_s.cur = tgt;
                next_s.addr = s.profs[tgt].start_a;
                pi.tm_load = 1'b1;
                pi.tm_period = s.profs[tgt].rate;
                hit = s.profs[tgt].start_a == s.profs[tgt].end_a;
            end
        end

        if (commit || (s.state == SEQ_RUN && pi.tm_expire && s.at_end) || hit)
            next_s.at_end = hit;
        if (hit)
        begin
            next_s.pulse_cnt = `SWEEP_PULSE_CYC;
            ev_end = 1'b1;
        end

        // The output lags the pulse counter so the commit cycle stays low.
        // After a halt the counter simply runs out, so a late pulse is never cut short.
        next_s.sweep = next_s.ram_en && (s.pulse_cnt != '0)
            && !commit;

        ////////////////////////////////////////////////////////////////////
        // Playback read and destination routing.

        if (s.state == SEQ_IDLE)
            pi.rd_addr = s.profs[PROFILE_SEL].start_a;
        else
            pi.rd_addr = s.addr;
        // A halted burst applies no read data, so the last applied word stays; the
        // commit cycle's read used the old setup and is dropped.
        next_s.rd_valid = next_s.ram_en && next_s.state != SEQ_HALT && !pi.wr_en
            && !commit;
        if (s.rd_valid)
        begin
            unique case (s.dest)
                `DEST_FREQ:
                    next_s.freq = pi.rd_data;
                `DEST_PHASE:
                    next_s.phase = pi.rd_data[31:16];
                `DEST_AMP:
                    next_s.amp = pi.rd_data[31:18];
                default:
                begin
                    next_s.phase = pi.rd_data[31:16];
                    next_s.amp = pi.rd_data[15:2];
                end
            endcase
        end

        ////////////////////////////////////////////////////////////////////
        // Interrupts: a read clears only the bits it returned; set wins.

        if (access && !PWRITE && PADDR == `IRQST_OFS)
            next_s.irq_st = s.irq_st & ~s.prdata[1:0];
        next_s.irq_st = next_s.irq_st | {ev_burst, ev_end};
        next_s.irq = |(next_s.irq_st & next_s.irq_mask);
    end

    ////////////////////////////////////////////////////////////////////////

    always_ff @(posedge REF_CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            s <= '0;
            s.ctrl <= `CTRL_RESET;
            s.state <= SEQ_IDLE;
        end
        else if (CE)
        begin
            s <= next_s;
        end
    end

    assign PRDATA = s.prdata;
    assign PREADY = s.pready;
    assign PSLVERR = s.pslverr;
    assign SWEEP_DONE_OUT = s.sweep;
    assign FREQ_WORD = s.freq;
    assign PHASE_WORD = s.phase;
    assign AMP_WORD = s.amp;
    assign IRQ = s.irq;

endmodule // ram_internal_profile_sequencer

`default_nettype wire

// [src/rate_timer.sv]
/*
  Address step timer: expires once every tm_period enabled cycles.
  Assumes the controller loads it on each profile entry.
*/
`timescale 1ns/1ps
`default_nettype none

module rate_timer
    import seq_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    play_if.timer p
);

    timer_state_t s;
    timer_state_t next_s;

    // A period of zero behaves as one so the timer can never stall.
    always_comb
    begin
        next_s = s;
        if (p.tm_load)
        begin
            next_s.per = p.tm_period;
            next_s.cnt = (p.tm_period > 1) ? p.tm_period - 1'b1 : '0;
        end
        else if (p.tm_run)
        begin
            next_s.cnt = (s.cnt == '0) ? ((s.per > 1) ? s.per - 1'b1 : '0) : s.cnt - 1'b1;
        end
    end

    // Expiry must not look at the load that it causes, or the two would chase each other.
    assign p.tm_expire = p.tm_run && (s.cnt == '0);

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            s <= '0;
        else if (p.ce)
            s <= next_s;
    end

endmodule // rate_timer

`default_nettype wire

// [src/seq_pkg.sv]
/*
  Types shared by the profile sequencer modules.
  Assumes seq_regs.svh for all numeric register layout.
*/
package seq_pkg;

    localparam int ADDR_W = 10;
    localparam int RATE_W = 16;
    localparam int NPROF = 8;

    typedef enum logic [1:0] {SEQ_IDLE, SEQ_RUN, SEQ_HALT} seq_state_t;

    typedef struct packed {
        logic [RATE_W-1:0] rate;
        logic [ADDR_W-1:0] end_a;
        logic [ADDR_W-1:0] start_a;
    } prof_t;

    typedef struct packed {
        logic [31:0] ctrl;
        logic [3:0] seq;
        logic [1:0] dest;
        logic ram_en;
        prof_t [NPROF-1:0] profs;
        seq_state_t state;
        logic [2:0] cur;
        logic [ADDR_W-1:0] addr;
        logic at_end;
        logic [1:0] pulse_cnt;
        logic burst_done;
        logic [ADDR_W-1:0] ram_ptr;
        logic rd_valid;
        logic [1:0] irq_st;
        logic [1:0] irq_mask;
        logic irq;
        logic sweep;
        logic [31:0] freq;
        logic [15:0] phase;
        logic [13:0] amp;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } top_state_t;

    typedef struct packed {
        logic [RATE_W-1:0] per;
        logic [RATE_W-1:0] cnt;
    } timer_state_t;

endpackage

// [src/seq_regs.svh]
/*
  Register offsets, field positions, reset values and cycle counts of the
  profile sequencer. Assumes a byte-addressed APB with 32-bit words.
*/
`ifndef SEQ_REGS_SVH
`define SEQ_REGS_SVH

`define CTRL_OFS 8'h00
`define COMMIT_OFS 8'h04
`define RAMPTR_OFS 8'h08
`define RAMDAT_OFS 8'h0C
`define STATUS_OFS 8'h10
`define IRQST_OFS 8'h14
`define IRQMSK_OFS 8'h18
`define PROF_BASE 8'h40
`define PROF_MASK 8'hC0

`define CTRL_RAMEN_BIT 0
`define CTRL_SEQ_LSB 17
`define CTRL_SEQ_MSB 20
`define CTRL_DEST_LSB 29
`define CTRL_DEST_MSB 30
`define CTRL_RESET 32'h0000_0000

`define PROF_END_LSB 16
`define PROF_END_MSB 25

`define STAT_RUN_BIT 0
`define STAT_DONE_BIT 1
`define STAT_CUR_LSB 2
`define STAT_ADDR_LSB 16

`define SEQ_OFF 4'h0
`define SEQ_INVALID 4'hF
`define SEQ_WRAP_OFS 4'h7

`define DEST_FREQ 2'h0
`define DEST_PHASE 2'h1
`define DEST_AMP 2'h2

`define SWEEP_PULSE_CYC 2'h2

`endif

// [src/wave_ram.sv]
/*
  Waveform RAM: one write port from the register bus, one registered read
  port for playback. Assumes the read address is held by the controller.
*/
`timescale 1ns/1ps
`default_nettype none

module wave_ram
    import seq_pkg::*;
#(
    parameter int WORDS = 1024
)
(
    input wire logic clk,
    input wire logic rst_n,
    play_if.mem p
);

    logic [31:0] mem [WORDS];
    logic [31:0] rd;

    always_ff @(posedge clk)
    begin
        if (p.ce && p.wr_en)
            mem[p.wr_addr] <= p.wr_data;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            rd <= '0;
        else if (p.ce)
            rd <= mem[p.rd_addr];
    end

    assign p.rd_data = rd;

endmodule // wave_ram

`default_nettype wire

// [tb/apb_host.sv]
/*
  Host controller model: an APB master that programs and commits.
  Assumes one clock and a slave that ends each access with pready.
*/
`timescale 1ns/1ps
`include "seq_regs.svh"
`default_nettype none

module apb_host
(
    input wire logic clk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end

    // The request stays put until pready is seen at an edge.
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
            @(posedge clk);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        xfer(1'b1, a, d, q, e);
    endtask

    // The invalid code is never sent, so it is cleared to off here.
    task automatic start(input logic [31:0] c);
        wr(`CTRL_OFS, c[20:17] == `SEQ_INVALID ? c & ~32'h001E_0000 : c);
        wr(`COMMIT_OFS, 32'h0);
    endtask
endmodule // apb_host

`default_nettype wire

// [tb/seq_chk.sv]
/*
  Checker of the sequencer's bus answers, done pulse and routing.
  Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/1ps
`include "seq_regs.svh"
`default_nettype none

module seq_chk
(
    input wire logic REF_CLK,
    input wire logic RESETN,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire logic SWEEP_DONE_OUT,
    input wire logic [15:0] PHASE_WORD,
    input wire logic [13:0] AMP_WORD
);
    logic wr;
    logic commit;
    logic off;
    logic ctl_en;
    logic act_en;
    logic [1:0] ctl_dest;
    logic [1:0] act_dest;
    logic [3:0] since;
    assign wr = PSEL && PENABLE && PREADY && PWRITE;
    assign commit = wr && PADDR == `COMMIT_OFS;
    assign off = !ctl_en && !act_en;

    //////////////////////////////////////////////////////////////////
    // The enable and destination fields and their committed copies are rebuilt from writes.
    always_ff @(posedge REF_CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            ctl_en <= 1'b0;
            act_en <= 1'b0;
            ctl_dest <= 2'h0;
            act_dest <= 2'h0;
            since <= 4'h0;
        end
        else
        begin
            if (wr && PADDR == `CTRL_OFS)
            begin
                ctl_en <= PWDATA[`CTRL_RAMEN_BIT];
                ctl_dest <= PWDATA[`CTRL_DEST_MSB:`CTRL_DEST_LSB];
            end
            if (commit)
            begin
                act_en <= ctl_en;
                act_dest <= ctl_dest;
            end
            since <= commit ? 4'h0 : (since == 4'hF ? since : since + 4'h1);
        end
    end

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RESETN);

    AST_SETUP_ANSWER: assert property (PSEL && !PENABLE |=> PREADY)
        else $error("no ready after setup");
    AST_READY_ONE: assert property (PREADY |=> !PREADY)
        else $error("ready held too long");
    AST_ERR_WITH_READY: assert property (PSLVERR |-> PREADY)
        else $error("error without ready");
    AST_ERR_READ_ZERO: assert property (PSLVERR && !PWRITE |-> PRDATA == 32'h0)
        else $error("refused read gave data");
    AST_SWEEP_TWO: assert property ($rose(SWEEP_DONE_OUT) && !commit |=>
        SWEEP_DONE_OUT ##1 !SWEEP_DONE_OUT)
        else $error("done pulse not two cycles");
    AST_COMMIT_LOW: assert property (commit |=> ##[0:1] !SWEEP_DONE_OUT)
        else $error("done not cleared by commit");
    AST_RAMOFF_LOW: assert property (off && $past(off) |-> !SWEEP_DONE_OUT)
        else $error("done high with RAM off");
    AST_DEST_FREQ_ONLY: assert property (act_dest == `DEST_FREQ
        && ctl_dest == `DEST_FREQ && since > 4'h4
        |-> $stable(PHASE_WORD) && $stable(AMP_WORD))
        else $error("phase or amplitude moved");

    cover property (commit);
    cover property ($rose(SWEEP_DONE_OUT));
    cover property (PSLVERR);
endmodule // seq_chk

bind ram_internal_profile_sequencer seq_chk i_seq_chk
(
    .REF_CLK(REF_CLK), .RESETN(RESETN), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .SWEEP_DONE_OUT(SWEEP_DONE_OUT),
    .PHASE_WORD(PHASE_WORD), .AMP_WORD(AMP_WORD)
);

`default_nettype wire

// [tb/tb_ram_internal_profile_sequencer.sv]
/*
  Self-checking bench: random profiles, every sequencing code, routing,
  interrupt and a refused access.
  Assumes the host model and the bound checker are compiled before it.
*/
`timescale 1ns/1ps
`include "seq_regs.svh"
`default_nettype none

module tb_ram_internal_profile_sequencer
    import seq_pkg::*;
;
    logic REF_CLK;
    logic RESETN = 1'b0;
    logic CE = 1'b1;
    logic PSEL, PENABLE, PWRITE, PREADY, PSLVERR, SWEEP_DONE_OUT, IRQ;
    logic [7:0] PADDR;
    logic [31:0] PWDATA, PRDATA, FREQ_WORD, rd, fw;
    logic [15:0] PHASE_WORD, seed, ph, pin_rnd = 16'h20EC;
    logic [13:0] AMP_WORD, am;
    logic [2:0] PROFILE_SEL = 3'h0;
    logic [2:0] idle_sel = 3'h5;
    logic watch = 1'b0;
    logic prev_sw = 1'b0;
    logic er;
    logic [9:0] st [NPROF];
    logic [9:0] en [NPROF];
    logic [2:0] rt [NPROF];
    logic [31:0] memw [1024];
    logic [13:0] q [$];
    int errors = 0;
    int n_tests = 0;
    int pulses = 0;
    int gap = 0;

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            errors++;
            $display("mismatch at %0t: saw %h, want %h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish;
        $display("checks %0d, mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial
    begin
        REF_CLK = 1'b0;
        forever #2.5 REF_CLK = ~REF_CLK;
    end

    ram_internal_profile_sequencer i_ram_internal_profile_sequencer
    (
        .REF_CLK(REF_CLK), .RESETN(RESETN), .CE(CE), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
        .PREADY(PREADY), .PSLVERR(PSLVERR), .PROFILE_SEL(PROFILE_SEL),
        .SWEEP_DONE_OUT(SWEEP_DONE_OUT), .FREQ_WORD(FREQ_WORD),
        .PHASE_WORD(PHASE_WORD), .AMP_WORD(AMP_WORD), .IRQ(IRQ)
    );

    apb_host i_apb_host
    (
        .clk(REF_CLK), .psel(PSEL), .penable(PENABLE), .pwrite(PWRITE), .paddr(PADDR),
        .pwdata(PWDATA), .prdata(PRDATA), .pready(PREADY), .pslverr(PSLVERR)
    );

    //////////////////////////////////////////////////////////////////
    // Each new played word is matched against the planned address queue.
    always @(posedge REF_CLK)
    begin
        logic [13:0] e;
        PROFILE_SEL <= watch ? pin_rnd[2:0] : idle_sel;
        pin_rnd <= lfsr(pin_rnd);
        prev_sw <= SWEEP_DONE_OUT;
        if (SWEEP_DONE_OUT === 1'b1 && prev_sw === 1'b0)
            pulses++;
        fw <= FREQ_WORD;
        gap <= gap + 1;
        if (watch && FREQ_WORD !== fw)
        begin
            gap <= 1;
            if (q.size() == 0)
                check(FREQ_WORD, fw);
            else
            begin
                e = q.pop_front();
                check(FREQ_WORD, memw[e[9:0]]);
                if (!e[13])
                    check(gap, e[12:10]);
            end
        end
    end

    initial
    begin
        #200us;
        errors++;
        tally_and_finish;
    end

    initial
    begin
        int n, a, code, last, cyc;
        seed = 16'h20EC;
        ph = 16'h0;
        am = 14'h0;
        repeat (8) @(posedge REF_CLK);
        RESETN <= 1'b1;
        i_apb_host.xfer(1'b0, `CTRL_OFS, 32'h0, rd, er);
        check(rd, `CTRL_RESET);
        i_apb_host.xfer(1'b0, `STATUS_OFS, 32'h0, rd, er);
        check(rd, 32'h0);
        i_apb_host.xfer(1'b0, 8'h20, 32'h0, rd, er);
        check(rd, 32'h0);
        check(er, 1'b1);
        // Regions run downward with junk in spare bits of the profile word.
        for (n = 0; n < NPROF; n++)
        begin
            seed = lfsr(seed);
            st[n] = 10'(1000 - 120 * n + seed[2:0]);
            en[n] = st[n] + 10'(1 + seed[4:3] % 3);
            rt[n] = 3'(2 + seed[6:5]);
            i_apb_host.wr(`PROF_BASE + 8'(8 * n), {seed[15:10], en[n], 6'h0, st[n]});
            i_apb_host.wr(`PROF_BASE + 8'(8 * n + 4), {29'h0, rt[n]});
            i_apb_host.wr(`RAMPTR_OFS, {22'h0, st[n]});
            for (a = st[n]; a <= en[n]; a++)
            begin
                seed = lfsr(seed);
                memw[a] = {seed, 6'h0, 10'(a)};
                i_apb_host.wr(`RAMDAT_OFS, memw[a]);
            end
        end
        for (code = 1; code < 15; code++)
        begin
            last = code < 8 ? code : code - 7;
            q.delete();
            for (cyc = 0; cyc < (code < 8 ? 1 : 3); cyc++)
                for (n = 0; n <= last; n++)
                    for (a = st[n]; a <= en[n]; a++)
                        q.push_back({a == st[n], rt[n], 10'(a)});
            pulses = 0;
            // Watching starts at the commit edge, so an idle word chosen by the pins
            // while the setup is still being written is not taken for playback.
            i_apb_host.start({11'h0, 4'(code), 16'h0, 1'b1});
            watch = 1'b1;
            for (n = 0; n < 4000 && pulses < (code < 8 ? last + 1 : 2 * last + 2); n++)
                @(posedge REF_CLK);
            if (code < 8)
            begin
                repeat (40) @(posedge REF_CLK);
                check(pulses, last + 1);
                check(q.size(), 0);
                i_apb_host.xfer(1'b0, `STATUS_OFS, 32'h0, rd, er);
                check(rd[1:0], 2'h2);
            end
            else
            begin
                check(pulses, 2 * last + 2);
                watch = 1'b0;
                i_apb_host.xfer(1'b0, `STATUS_OFS, 32'h0, rd, er);
                check(rd[0], 1'b1);
                i_apb_host.start(32'h1);
                i_apb_host.xfer(1'b0, `STATUS_OFS, 32'h0, rd, er);
                check(rd[1:0], 2'h0);
            end
            if (code == 1)
            begin
                check(IRQ, 1'b0);
                i_apb_host.wr(`IRQMSK_OFS, 32'h2);
                repeat (2) @(posedge REF_CLK);
                check(IRQ, 1'b1);
                i_apb_host.xfer(1'b0, `IRQST_OFS, 32'h0, rd, er);
                check(rd, 32'h3);
                repeat (2) @(posedge REF_CLK);
                check(IRQ, 1'b0);
                i_apb_host.xfer(1'b0, `IRQST_OFS, 32'h0, rd, er);
                check(rd, 32'h0);
            end
        end
        pulses = 0;
        i_apb_host.start({11'h0, 4'h1, 17'h0});
        repeat (300) @(posedge REF_CLK);
        check(pulses, 0);
        for (n = 1; n < 4; n++)
        begin
            // The pins move only once the new destination is live.
            i_apb_host.start({1'b0, 2'(n), 29'h1});
            idle_sel = 3'(n + 2);
            repeat (8) @(posedge REF_CLK);
            rd = memw[st[n + 2]];
            if (n != 2)
                ph = rd[31:16];
            am = n == 2 ? rd[31:18] : (n == 3 ? rd[15:2] : am);
            check(PHASE_WORD, ph);
            check(AMP_WORD, am);
        end
        tally_and_finish;
    end
endmodule // tb_ram_internal_profile_sequencer

`default_nettype wire
